// ---- sifm_checker.sv ----
// sifm_checker: port-level assertions for the monitor top.
// assumes one clock domain and synchronous active-high reset.
module sifm_checker
	import sifm_pkg::*;
#(
	parameter int unsigned N_TEMP = 4
) (
	input wire logic              i_clock,
	input wire logic              i_sys_rst,
	input wire logic              i_sys_loop_closed,
	input wire logic              i_shut_loop_closed,
	input wire logic [N_TEMP-1:0] i_temp_out_of_range,
	input wire logic              o_shut_closed_stat,
	input wire logic              o_shut_open_stat,
	input wire logic              o_shut_fault,
	input wire logic              o_over_temp_fault,
	input wire logic              o_shut_drive_en,
	input wire logic              o_interlock_good,
	input wire logic              o_laser_enable,
	input wire logic              o_shutdown
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// status pins go quiet while any fault stands
	closed_stat_a: assert property (o_shut_closed_stat |-> !o_shutdown)
		else $error("closed status during fault");
	open_stat_a: assert property (o_shut_open_stat |->
		!o_shutdown && !o_shut_closed_stat) else $error("bad open status");
	shutdown_any_a: assert property (o_shutdown ==
		(o_shut_fault || o_over_temp_fault)) else $error("shutdown mismatch");
	shut_latch_a: assert property (o_shut_fault |=> o_shut_fault)
		else $error("shutter fault dropped");
	temp_latch_a: assert property (o_over_temp_fault |=>
		$stable(o_over_temp_fault)) else $error("temperature fault dropped");
	temp_flag_a: assert property ((|i_temp_out_of_range) [*3]
		|=> o_over_temp_fault) else $error("temperature fault late");
	loop_open_a: assert property (!i_sys_loop_closed [*3]
		|=> !o_interlock_good && !o_laser_enable) else $error("loop ignored");
	loop_good_a: assert property ((!i_sys_rst && i_sys_loop_closed) [*3]
		|=> o_interlock_good) else $error("interlock good missing");
	laser_gate_a: assert property (o_laser_enable |->
		o_interlock_good && !o_shutdown) else $error("laser enabled wrongly");
	no_shutter_a: assert property (!i_shut_loop_closed [*3] |=>
		!o_shut_drive_en && !o_shut_open_stat && !o_shut_closed_stat)
		else $error("shutter active without fitting");
	// main scenarios reached
	cover property ($rose(o_shut_fault));
	cover property ($rose(o_over_temp_fault));
	cover property ($rose(o_shut_open_stat));
endmodule : sifm_checker

bind sifm_top sifm_checker #(.N_TEMP(N_TEMP)) u_chk (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_sys_loop_closed(i_sys_loop_closed),
	.i_shut_loop_closed(i_shut_loop_closed),
	.i_temp_out_of_range(i_temp_out_of_range),
	.o_shut_closed_stat(o_shut_closed_stat),
	.o_shut_open_stat(o_shut_open_stat), .o_shut_fault(o_shut_fault),
	.o_over_temp_fault(o_over_temp_fault), .o_shut_drive_en(o_shut_drive_en),
	.o_interlock_good(o_interlock_good), .o_laser_enable(o_laser_enable),
	.o_shutdown(o_shutdown));

// ---- sifm_pkg.sv ----
// sifm_pkg: constants for the shutter interlock and fault monitor.
// assumes a 100 MHz system clock and synchronous active-high reset.
package sifm_pkg;
	localparam int unsigned CLK_MHZ        = 100;
	// shutter travel allowance, in microseconds
	localparam int unsigned TRAVEL_US      = 500;
	localparam int unsigned TRAVEL_CYC     = TRAVEL_US * CLK_MHZ;
	// closed-position grace after a close request, in microseconds
	localparam int unsigned CLOSE_GRACE_US = 500;
	localparam int unsigned CLOSE_GRACE_CYC = CLOSE_GRACE_US * CLK_MHZ;
	localparam int unsigned SYNC_STAGES    = 2;
	localparam logic        FAULT_RST      = 1'b0;
	localparam logic        DRIVE_RST      = 1'b0;
	typedef enum logic [1:0] {
		SIFM_IDLE,
		SIFM_MOVING,
		SIFM_FAULT
	} sifm_state_t;
endpackage : sifm_pkg

// ---- sifm_shutter_model.sv ----
// sifm_shutter_model: behavioural beam shutter with two position sensors.
// assumes drive pins from the monitor; i_fail is a bench knob.
module sifm_shutter_model #(
	parameter int unsigned TRAVEL = 6
) (
	input  wire logic i_clock,
	input  wire logic i_drive_open,
	input  wire logic i_drive_en,
	input  wire logic i_fail,
	output logic      o_pos_open,
	output logic      o_pos_closed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        is_open_q = 1'b0;
	int unsigned cnt_q     = 0;
	// blade follows drive
	// an unpowered or jammed blade stays where it stands
	always @(posedge i_clock) begin
		if (!i_drive_en || i_fail || i_drive_open == is_open_q) begin
			cnt_q <= 0;
		end else if (cnt_q == TRAVEL - 1) begin
			is_open_q <= i_drive_open;
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	// mid-travel or broken sensors read neither position
	assign o_pos_open   = !i_fail && cnt_q == 0 && is_open_q;
	assign o_pos_closed = !i_fail && cnt_q == 0 && !is_open_q;
endmodule : sifm_shutter_model

// ---- sifm_sync.sv ----
// sifm_sync: two-flop synchroniser bank for asynchronous pin levels.
// assumes the inputs are quasi-static levels from outside the clock domain.
module sifm_sync
	import sifm_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	initial begin
		if (WIDTH < 1) $error("sifm_sync: WIDTH must be at least 1");
	end
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;
	// first stage feeds only the second stage
	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
	end
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign o_sync = sync_q;
endmodule : sifm_sync

// ---- sifm_timer.sv ----
// sifm_timer: restartable down-counter that flags expiry.
// assumes i_start is a one-cycle pulse from logic on the same clock.
module sifm_timer
	import sifm_pkg::*;
#(
	parameter int unsigned COUNT = 50000
) (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_start,
	input  wire logic i_run,
	output logic      o_expired
);
	localparam int unsigned W = $clog2(COUNT + 1);
	initial begin
		if (COUNT < 1) $error("sifm_timer: COUNT must be at least 1");
	end
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         exp_q;
	logic         exp_d;
	// counts only while running; stopping freezes and clears the flag
	always_comb begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (i_start) begin
			cnt_d = W'(COUNT);
		end else if (i_run) begin
			if (cnt_q != '0) begin
				cnt_d = cnt_q - W'(1);
			end
			exp_d = (cnt_q == W'(1)) || (cnt_q == '0);
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end
	assign o_expired = exp_q;
endmodule : sifm_timer

// ---- sifm_top.sv ----
// sifm_top: shutter interlock, shutter position and latched fault monitor.
// assumes interlock loops, position sensors and command are pin levels,
// and each peripheral controller gives one over-temperature level.
// What this block does
// - closed status only when present, closed, unfaulted
// - open status only when present, open, unfaulted
// - shutter follows command level, high opens
// - travel timeout either way latches shutter fault
// - close requested but not sensed closed faults
// - shutter fault latches and shuts system down
// - any controller out of range flags over-temperature
// - over-temperature latches and shuts system down
// - open system loop drops interlock-good and the laser enable, not the shutter
// - shutter runs only when fitted and unfaulted; interlock never inhibits it
// - interlock-good flag gates laser operation
// - closed shutter loop means shutter fitted
module sifm_top
	import sifm_pkg::*;
#(
	parameter int unsigned N_TEMP          = 4,
	parameter int unsigned TRAVEL_COUNT    = TRAVEL_CYC,
	parameter int unsigned CLOSE_GRACE_CNT = CLOSE_GRACE_CYC
) (
	input  wire logic              i_clock,
	input  wire logic              i_sys_rst,
	input  wire logic              i_sys_loop_closed,
	input  wire logic              i_shut_loop_closed,
	input  wire logic              i_shut_cmd_open,
	input  wire logic              i_pos_open,
	input  wire logic              i_pos_closed,
	input  wire logic [N_TEMP-1:0] i_temp_out_of_range,
	input  wire logic              i_laser_enable_req,
	output logic                   o_shut_closed_stat,
	output logic                   o_shut_open_stat,
	output logic                   o_shut_fault,
	output logic                   o_over_temp_fault,
	output logic                   o_shut_drive_open,
	output logic                   o_shut_drive_en,
	output logic                   o_interlock_good,
	output logic                   o_laser_enable,
	output logic                   o_shutdown
);
	// elaboration checks: a zero count would expire before any move
	initial begin
		if (N_TEMP < 1) $error("sifm_top: N_TEMP must be at least 1");
		if (TRAVEL_COUNT < 1) $error("sifm_top: TRAVEL_COUNT too small");
		if (CLOSE_GRACE_CNT < 1) $error("sifm_top: CLOSE_GRACE_CNT too small");
	end

	// synchroniser bit map: 0 system loop, 1 shutter loop, 2 command,
	// 3 open sensor, 4 closed sensor, then one bit per temperature
	// controller; the bank resets low, so both loops read open until
	// the pins have been sampled twice after reset
	localparam int unsigned NS = 5 + N_TEMP;

	// every pin level except i_laser_enable_req passes the synchroniser before use
	logic [NS-1:0] pins_sync;
	sifm_sync #(
		.WIDTH(NS)
	) u_sync (
		.i_clock  (i_clock),
		.i_sys_rst(i_sys_rst),
		.i_async  ({i_temp_out_of_range, i_pos_closed, i_pos_open,
		            i_shut_cmd_open, i_shut_loop_closed,
		            i_sys_loop_closed}),
		.o_sync   (pins_sync)
	);

	logic              sys_loop;
	logic              shut_loop;
	logic              cmd_open;
	logic              pos_open;
	logic              pos_closed;
	logic [N_TEMP-1:0] temp_bad;
	// unpack the synchronised levels
	assign sys_loop   = pins_sync[0];
	assign shut_loop  = pins_sync[1];
	assign cmd_open   = pins_sync[2];
	assign pos_open   = pins_sync[3];
	assign pos_closed = pins_sync[4];
	assign temp_bad   = pins_sync[NS-1:5];

	// per-controller over-temperature flags, OR-reduced below
	// no per-controller latch: the shared latch is what the ports show
	logic [N_TEMP-1:0] temp_hit;
	genvar g;
	generate
		for (g = 0; g < N_TEMP; g++) begin : g_temp
			assign temp_hit[g] = temp_bad[g];
		end
	endgenerate

	// the shutter loop only marks the shutter fitted; the laser enable
	// below never reads it
	// loop closed means fitted
	logic present;
	assign present = shut_loop;

	// state for shutter supervision
	// tgt_q is the last accepted command; the drive pin follows it
	sifm_state_t st_q;
	sifm_state_t st_d;
	logic        tgt_q;
	logic        tgt_d;
	logic        shut_flt_q;
	logic        shut_flt_d;
	logic        ot_flt_q;
	logic        ot_flt_d;
	logic        trav_start;
	logic        grace_start;
	logic        trav_exp;
	logic        grace_exp;
	logic        at_target;
	logic        close_miss;

	// travel timer runs while the shutter is moving; a reversal reloads
	// it, so a controller that keeps reversing never trips the timeout
	sifm_timer #(
		.COUNT(TRAVEL_COUNT)
	) u_travel (
		.i_clock  (i_clock),
		.i_sys_rst(i_sys_rst),
		.i_start  (trav_start),
		.i_run    (st_q == SIFM_MOVING),
		.o_expired(trav_exp)
	);

	// grace timer: a close request not sensed closed, outside any move,
	// must persist this long; it debounces sensor chatter
	sifm_timer #(
		.COUNT(CLOSE_GRACE_CNT)
	) u_grace (
		.i_clock  (i_clock),
		.i_sys_rst(i_sys_rst),
		.i_start  (grace_start),
		.i_run    (close_miss),
		.o_expired(grace_exp)
	);

	// a move completes only on exactly one lit sensor; both lit is a broken
	// harness and is left to the travel timeout to catch
	assign at_target = tgt_q ? (pos_open && !pos_closed)
	                         : (pos_closed && !pos_open);
	assign close_miss = present && !cmd_open && !pos_closed
	                    && (st_q == SIFM_IDLE);
	// the rising edge of a miss reloads the grace timer, so a sensor
	// that chatters restarts the wait instead of adding up
	logic close_miss_q;
	logic close_miss_d;
	assign close_miss_d = close_miss;
	assign grace_start  = close_miss && !close_miss_q;

	// miss-edge register
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			close_miss_q <= 1'b0;
		end else begin
			close_miss_q <= close_miss_d;
		end
	end

	// next-state logic for the shutter supervisor and fault latches
	always_comb begin
		st_d       = st_q;
		tgt_d      = tgt_q;
		trav_start = 1'b0;
		shut_flt_d = shut_flt_q;
		ot_flt_d   = ot_flt_q;
		if (|temp_hit) begin
			ot_flt_d = 1'b1;
		end
		case (st_q)
			SIFM_IDLE: begin
				if (present && (cmd_open != tgt_q)) begin
					tgt_d      = cmd_open;
					st_d       = SIFM_MOVING;
					trav_start = 1'b1;
				end else if (present && grace_exp && close_miss) begin
					// close not sensed
					// re-test the miss: the expiry flag lags it by one edge
					st_d       = SIFM_FAULT;
					shut_flt_d = 1'b1;
				end
			end
			SIFM_MOVING: begin
				if (!present) begin
					// loop opened mid-move: drop supervision, raise no fault
					st_d = SIFM_IDLE;
				end else if (at_target) begin
					// move done
					st_d = SIFM_IDLE;
				end else if (trav_exp) begin
					st_d       = SIFM_FAULT;
					shut_flt_d = 1'b1;
				end else if (cmd_open != tgt_q) begin
					// reversal restarts the travel allowance
					tgt_d      = cmd_open;
					trav_start = 1'b1;
				end
			end
			SIFM_FAULT: begin
				st_d = SIFM_FAULT;
			end
			default: begin
				st_d = SIFM_FAULT;
			end
		endcase
		if (shut_flt_q) begin
			shut_flt_d = 1'b1;
		end
	end

	// supervisor registers; reset leaves the shutter commanded closed
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st_q       <= SIFM_IDLE;
			tgt_q      <= DRIVE_RST;
			shut_flt_q <= FAULT_RST;
			ot_flt_q   <= FAULT_RST;
		end else begin
			st_q       <= st_d;
			tgt_q      <= tgt_d;
			shut_flt_q <= shut_flt_d;
			ot_flt_q   <= ot_flt_d;
		end
	end

	// registered outputs
	logic closed_stat_d;
	logic open_stat_d;
	logic drive_open_d;
	logic drive_en_d;
	logic ilk_good_d;
	logic laser_en_d;
	logic shutdown_d;
	logic any_fault;
	logic closed_stat_q;
	logic open_stat_q;
	logic drive_open_q;
	logic drive_en_q;
	logic ilk_good_q;
	logic laser_en_q;
	logic shutdown_q;

	// output decode; faults blank both position indications
	// the decode reads the next fault values, so the edge that latches a
	// fault also drops the status pins and the laser enable with it
	always_comb begin
		any_fault     = shut_flt_d || ot_flt_d;
		closed_stat_d = present && pos_closed && !pos_open && !any_fault;
		open_stat_d   = present && pos_open && !pos_closed && !any_fault;
		drive_en_d    = present && !any_fault;
		drive_open_d  = drive_en_d && tgt_d;
		ilk_good_d    = sys_loop;
		shutdown_d    = any_fault;
		laser_en_d    = ilk_good_d && !any_fault && i_laser_enable_req;
	end

	// output registers; every port except the two fault flags comes straight from one of these
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			closed_stat_q <= 1'b0;
			open_stat_q   <= 1'b0;
			drive_open_q  <= DRIVE_RST;
			drive_en_q    <= 1'b0;
			ilk_good_q    <= 1'b0;
			laser_en_q    <= 1'b0;
			shutdown_q    <= 1'b0;
		end else begin
			closed_stat_q <= closed_stat_d;
			open_stat_q   <= open_stat_d;
			drive_open_q  <= drive_open_d;
			drive_en_q    <= drive_en_d;
			ilk_good_q    <= ilk_good_d;
			laser_en_q    <= laser_en_d;
			shutdown_q    <= shutdown_d;
		end
	end

	// ports are wired straight to flip-flops
	assign o_shut_closed_stat = closed_stat_q;
	assign o_shut_open_stat   = open_stat_q;
	assign o_shut_fault       = shut_flt_q;
	assign o_over_temp_fault  = ot_flt_q;
	assign o_shut_drive_open  = drive_open_q;
	assign o_shut_drive_en    = drive_en_q;
	assign o_interlock_good   = ilk_good_q;
	assign o_laser_enable     = laser_en_q;
	assign o_shutdown         = shutdown_q;
endmodule : sifm_top

// ---- tb_top.sv ----
// tb_top: self-checking bench for the shutter interlock monitor.
// assumes short travel and grace counts of 20 cycles for run time.
`define CK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
	miscompares++; $display("BAD %s exp %b got %b", nm, exp, got); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clock = 1'b0, i_sys_rst = 1'b1, i_sys_loop_closed = 1'b1;
	logic       i_shut_loop_closed = 1'b1, i_shut_cmd_open = 1'b0;
	logic       i_laser_enable_req = 1'b1, fail = 1'b0;
	logic [3:0] i_temp_out_of_range = 4'h0;
	logic       i_pos_open, i_pos_closed, o_shut_closed_stat, o_shut_open_stat;
	logic       o_shut_fault, o_over_temp_fault, o_shut_drive_open;
	logic       o_shut_drive_en, o_interlock_good, o_laser_enable, o_shutdown;
	int         checks = 0, miscompares = 0, cycles = 0;
	always #5 i_clock = ~i_clock;
	sifm_top #(.N_TEMP(4), .TRAVEL_COUNT(20), .CLOSE_GRACE_CNT(20)) DUT (
		.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_sys_loop_closed(i_sys_loop_closed),
		.i_shut_loop_closed(i_shut_loop_closed),
		.i_shut_cmd_open(i_shut_cmd_open), .i_pos_open(i_pos_open),
		.i_pos_closed(i_pos_closed), .i_temp_out_of_range(i_temp_out_of_range),
		.i_laser_enable_req(i_laser_enable_req),
		.o_shut_closed_stat(o_shut_closed_stat),
		.o_shut_open_stat(o_shut_open_stat), .o_shut_fault(o_shut_fault),
		.o_over_temp_fault(o_over_temp_fault),
		.o_shut_drive_open(o_shut_drive_open), .o_shut_drive_en(o_shut_drive_en),
		.o_interlock_good(o_interlock_good), .o_laser_enable(o_laser_enable),
		.o_shutdown(o_shutdown));
	sifm_shutter_model u_shutter (.i_clock(i_clock),
		.i_drive_open(o_shut_drive_open), .i_drive_en(o_shut_drive_en),
		.i_fail(fail), .o_pos_open(i_pos_open), .o_pos_closed(i_pos_closed));
	// sample just after the edge so registered outputs have settled
	task wt(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : wt
	task do_reset;
		@(posedge i_clock) i_sys_rst <= 1'b1;
		fail <= 1'b0;
		i_shut_cmd_open <= 1'b0;
		i_temp_out_of_range <= 4'h0;
		wt(2);
		@(posedge i_clock) i_sys_rst <= 1'b0;
		wt(30);
	endtask : do_reset
	task wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// run is a few hundred cycles; a hang is cut off well past that
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		do_reset;
		`CK("closed", 1'b1, o_shut_closed_stat)
		`CK("good", 1'b1, o_interlock_good)
		`CK("laser", 1'b1, o_laser_enable)
		@(posedge i_clock) i_laser_enable_req <= 1'b0;
		wt(2);
		`CK("laser", 1'b0, o_laser_enable)
		@(posedge i_clock) i_laser_enable_req <= 1'b1;
		wt(2);
		`CK("laser", 1'b1, o_laser_enable)
		$display("test idle done");
		@(posedge i_clock) i_shut_cmd_open <= 1'b1;
		wt(4);
		`CK("drive", 1'b1, o_shut_drive_open)
		wt(15);
		`CK("open", 1'b1, o_shut_open_stat)
		`CK("closed", 1'b0, o_shut_closed_stat)
		$display("test open done");
		@(posedge i_clock) i_sys_loop_closed <= 1'b0;
		wt(5);
		`CK("good", 1'b0, o_interlock_good)
		`CK("laser", 1'b0, o_laser_enable)
		@(posedge i_clock) i_sys_loop_closed <= 1'b1;
		// unfitted shutter leaves its loop open
		i_shut_loop_closed <= 1'b0;
		wt(5);
		`CK("drive_en", 1'b0, o_shut_drive_en)
		`CK("open", 1'b0, o_shut_open_stat)
		`CK("laser", 1'b1, o_laser_enable)
		@(posedge i_clock) i_shut_loop_closed <= 1'b1;
		wt(10);
		$display("test loops done");
		@(posedge i_clock) fail <= 1'b1;
		i_shut_cmd_open <= 1'b0;
		wt(40);
		`CK("fault", 1'b1, o_shut_fault)
		`CK("shutdown", 1'b1, o_shutdown)
		`CK("laser", 1'b0, o_laser_enable)
		@(posedge i_clock) fail <= 1'b0;
		wt(20);
		`CK("fault", 1'b1, o_shut_fault)
		`CK("closed", 1'b0, o_shut_closed_stat)
		$display("test travel done");
		do_reset;
		@(posedge i_clock) fail <= 1'b1;
		wt(10);
		`CK("fault", 1'b0, o_shut_fault)
		wt(20);
		`CK("fault", 1'b1, o_shut_fault)
		$display("test grace done");
		for (int i = 0; i < 4; i++) begin
			do_reset;
			`CK("laser", 1'b1, o_laser_enable)
			@(posedge i_clock) i_temp_out_of_range <= 4'(1 << i);
			wt(4);
			`CK("temp", 1'b1, o_over_temp_fault)
			`CK("laser", 1'b0, o_laser_enable)
			@(posedge i_clock) i_temp_out_of_range <= 4'h0;
			wt(5);
			`CK("temp", 1'b1, o_over_temp_fault)
		end
		$display("test temperature done");
		wrap_up;
	end
endmodule : tb_top
